/* File: tcw_timer.sv */
// Timer event actions, compare channels, match flags and waveform outputs.
// Assumes a single AHB-Lite master with zero-wait single word transfers and
// event inputs that are one-cycle pulses synchronous to clk.
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps

module tcw_timer
	import tcw_pkg::*;
#(
	parameter int NCH = 2
) (
	input  wire logic           clk,
	input  wire logic           reset,
	input  wire logic           hsel,
	input  wire logic [31:0]    haddr,
	input  wire logic [1:0]     htrans,
	input  wire logic           hwrite,
	input  wire logic [2:0]     hsize,
	input  wire logic [31:0]    hwdata,
	input  wire logic           hready,
	output logic [31:0]         hrdata,
	output logic                hreadyout,
	output logic                hresp,
	input  wire logic           event_in,
	output logic [NCH-1:0]      match_event_out,
	output logic [NCH-1:0]      wave_out,
	output logic                irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0]          ctrl_reg,   ctrl_next;
	logic [31:0]          count_reg,  count_next;
	logic [7:0]           per_reg,    per_next;
	logic [NCH-1:0]       evout_en_reg, evout_en_next;
	logic [NCH-1:0]       inv_reg,    inv_next;
	logic [NCH-1:0]       flag_reg,   flag_next;
	logic [NCH-1:0]       inten_reg,  inten_next;
	logic [31:0]          cc_reg  [NCH];
	logic [31:0]          cc_next [NCH];
	tcw_run_t             run_reg,    run_next;
	logic [NCH-1:0]       wraw_reg,   wraw_next;
	logic [NCH-1:0]       wave_next;
	logic [NCH-1:0]       mev_next;
	logic                 irq_next;
	logic                 dwr_reg,    dwr_next;
	logic [7:0]           dadr_reg,   dadr_next;
	logic [31:0]          rdata_next;

	logic                 tick;
	logic                 addr_ok;
	logic                 wr_en;
	logic                 ctrl_wr;
	logic                 sw_retrig;
	logic                 sw_stop;
	logic                 retrig;
	logic                 step;
	logic                 down;
	logic [31:0]          maxv;
	logic [31:0]          top;
	logic [NCH-1:0]       hit;
	tcw_wave_t            wmode;
	logic [2:0]           eva;
	logic [1:0]           size;

	// Counter clock tick from the prescaler
	tcw_tick_div #(
		.DIV_W (10)
	) u_div (
		.clk                (clk),
		.reset              (reset),
		.prescale           (ctrl_reg[TCW_CTRL_PRE_LSB +: 4]),
		.counter_clock_tick (tick)
	);

	// ----------------------------------------------------------------
	// Decoded fields
	// ----------------------------------------------------------------
	assign down  = ctrl_reg[TCW_CTRL_DOWN];
	assign wmode = tcw_wave_t'(ctrl_reg[TCW_CTRL_WAVE_LSB +: 2]);
	assign eva   = ctrl_reg[TCW_CTRL_EVA_LSB +: 3];
	assign size  = ctrl_reg[TCW_CTRL_SIZE_LSB +: 2];

	// Bus write lands in the data phase, one cycle after the address phase
	assign addr_ok   = hsel && htrans[1] && hready;
	assign wr_en     = dwr_reg;
	assign ctrl_wr   = wr_en && (dadr_reg == TCW_OFS_CTRL);
	assign sw_retrig = wr_en && (dadr_reg == TCW_OFS_CMD) && hwdata[TCW_CMD_RETRIG];
	assign sw_stop   = wr_en && (dadr_reg == TCW_OFS_CMD) && hwdata[TCW_CMD_STOP];

	// Software command or event, depending on the selected action
	assign retrig = sw_retrig
		|| (event_in && ctrl_reg[TCW_CTRL_ENABLE] && (eva == TCW_EVA_RETRIG));

	// Counting advances on ticks, or on events in count action
	assign step = (run_reg == TCW_RUNNING)
		&& ((eva == TCW_EVA_COUNT) ? event_in : tick);

	// ----------------------------------------------------------------
	// Top value selection
	// ----------------------------------------------------------------
	always_comb begin
		case (size)
			TCW_SIZE_8:  maxv = 32'h0000_00ff;
			TCW_SIZE_32: maxv = 32'hffff_ffff;
			default:     maxv = 32'h0000_ffff;
		endcase
		case (wmode)
			TCW_MATCH_FREQUENCY_MODE,
			TCW_MATCH_PULSE_WIDTH_MODE: top = cc_reg[0] & maxv;
			default: top = (size == TCW_SIZE_8) ? {24'h0, per_reg}
				: maxv;
		endcase
	end

	// Every channel compared on every cycle, in every waveform mode
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_cmp
			assign hit[gi] = (count_reg == (cc_reg[gi] & maxv));
		end
	endgenerate

	// ----------------------------------------------------------------
	// Counter, run state and configuration
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_next     = ctrl_reg;
		count_next    = count_reg;
		per_next      = per_reg;
		evout_en_next = evout_en_reg;
		inv_next      = inv_reg;
		inten_next    = inten_reg;
		run_next      = run_reg;
		for (int i = 0; i < NCH; i++) begin
			cc_next[i] = cc_reg[i];
		end
		// Register writes
		if (wr_en) begin
			case (dadr_reg)
				TCW_OFS_CTRL:   ctrl_next     = hwdata[15:0];
				TCW_OFS_PER:    per_next      = hwdata[7:0];
				TCW_OFS_EVCTRL: evout_en_next = hwdata[NCH-1:0];
				TCW_OFS_INVERT: inv_next      = hwdata[NCH-1:0];
				TCW_OFS_INTEN:  inten_next    = hwdata[NCH-1:0];
				default: begin
					for (int i = 0; i < NCH; i++) begin
						if (dadr_reg == TCW_OFS_CMP0 + 8'(4 * i)) begin
							cc_next[i] = hwdata;
						end
					end
				end
			endcase
		end
		// Counting, with wrap at top or zero
		if (step) begin
			if (down) begin
				count_next = (count_reg == 32'h0) ? top : count_reg - 32'h1;
			end else begin
				count_next = (count_reg >= top) ? 32'h0 : count_reg + 32'h1;
			end
		end
		// Enable edge; restart_on_event_action and start actions wait for an event
		if (ctrl_wr && hwdata[TCW_CTRL_ENABLE] && !ctrl_reg[TCW_CTRL_ENABLE]) begin
			if ((hwdata[TCW_CTRL_EVA_LSB +: 3] != TCW_EVA_RETRIG)
				&& (hwdata[TCW_CTRL_EVA_LSB +: 3] != TCW_EVA_START)) begin
				run_next = TCW_RUNNING;
			end else begin
				run_next = TCW_STOPPED;
			end
		end
		// Start action: event starts only a stopped counter
		if (event_in && ctrl_reg[TCW_CTRL_ENABLE] && (eva == TCW_EVA_START)
			&& (run_reg == TCW_STOPPED)) begin
			run_next = TCW_RUNNING;
		end
		// Restart_on_event_action: reload or clear while running, resume while stopped
		if (retrig && ctrl_reg[TCW_CTRL_ENABLE]) begin
			if (run_reg == TCW_RUNNING) begin
				count_next = down ? top : 32'h0;
			end
			run_next = TCW_RUNNING;
		end
		// Software count write takes priority over counting
		if (wr_en && (dadr_reg == TCW_OFS_COUNT)) begin
			count_next = hwdata & maxv;
		end
		if (sw_stop || (ctrl_wr && !hwdata[TCW_CTRL_ENABLE])) begin
			run_next = TCW_STOPPED;
		end
	end

	// ----------------------------------------------------------------
	// Flags, events, waveforms and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		flag_next = flag_reg;
		mev_next  = '0;
		wraw_next = wraw_reg;
		// Write one clears, a zero leaves the flag alone
		if (wr_en && (dadr_reg == TCW_OFS_FLAG)) begin
			flag_next = flag_reg & ~hwdata[NCH-1:0];
		end
		for (int i = 0; i < NCH; i++) begin
			// Match seen at a counting step (tick, or event in count action); set wins over a same-cycle clear
			if (step && hit[i]) begin
				flag_next[i] = 1'b1;
				mev_next[i]  = evout_en_reg[i];
			end
			case (wmode)
				TCW_NORMAL_FREQUENCY_MODE,
				TCW_MATCH_FREQUENCY_MODE: begin
					if (step && hit[i]) begin
						wraw_next[i] = ~wraw_reg[i];
					end
				end
				TCW_NORMAL_PULSE_WIDTH_MODE,
				TCW_MATCH_PULSE_WIDTH_MODE: begin
					wraw_next[i] = down ? (count_reg > (cc_reg[i] & maxv))
						: (count_reg < (cc_reg[i] & maxv));
				end
				default: wraw_next[i] = wraw_reg[i];
			endcase
		end
		wave_next = wraw_next ^ inv_next;
		irq_next  = |(flag_next & inten_reg);
	end

	// ----------------------------------------------------------------
	// Bus address phase and read mux
	// ----------------------------------------------------------------
	always_comb begin
		dwr_next   = addr_ok && hwrite;
		dadr_next  = addr_ok ? {haddr[7:2], 2'b00} : dadr_reg;
		rdata_next = 32'h0;
		// Unmapped addresses read zero and still answer OKAY
		if (addr_ok && !hwrite) begin
			case ({haddr[7:2], 2'b00})
				TCW_OFS_CTRL:   rdata_next = {16'h0, ctrl_reg};
				TCW_OFS_CMD:    rdata_next = {31'h0, run_reg == TCW_RUNNING};
				TCW_OFS_COUNT:  rdata_next = count_reg;
				TCW_OFS_PER:    rdata_next = {24'h0, per_reg};
				TCW_OFS_EVCTRL: rdata_next = 32'(evout_en_reg);
				TCW_OFS_INVERT: rdata_next = 32'(inv_reg);
				TCW_OFS_FLAG:   rdata_next = 32'(flag_reg);
				TCW_OFS_INTEN:  rdata_next = 32'(inten_reg);
				default: begin
					for (int i = 0; i < NCH; i++) begin
						if ({haddr[7:2], 2'b00} == TCW_OFS_CMP0 + 8'(4 * i)) begin
							rdata_next = cc_reg[i];
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_reg        <= TCW_CTRL_RST;
			count_reg       <= TCW_COUNT_RST;
			per_reg         <= TCW_PER_RST;
			evout_en_reg    <= '0;
			inv_reg         <= '0;
			flag_reg        <= '0;
			inten_reg       <= '0;
			run_reg         <= TCW_STOPPED;
			wraw_reg        <= '0;
			wave_out        <= '0;
			match_event_out <= '0;
			irq             <= 1'b0;
			dwr_reg         <= 1'b0;
			dadr_reg        <= 8'h00;
			hrdata          <= 32'h0;
			hreadyout       <= 1'b1;
			hresp           <= 1'b0;
			for (int i = 0; i < NCH; i++) begin
				cc_reg[i] <= TCW_CC_RST;
			end
		end else begin
			ctrl_reg        <= ctrl_next;
			count_reg       <= count_next;
			per_reg         <= per_next;
			evout_en_reg    <= evout_en_next;
			inv_reg         <= inv_next;
			flag_reg        <= flag_next;
			inten_reg       <= inten_next;
			run_reg         <= run_next;
			wraw_reg        <= wraw_next;
			wave_out        <= wave_next;
			match_event_out <= mev_next;
			irq             <= irq_next;
			dwr_reg         <= dwr_next;
			dadr_reg        <= dadr_next;
			hrdata          <= rdata_next;
			hreadyout       <= 1'b1; // Zero wait states, never stretches
			hresp           <= 1'b0;
			for (int i = 0; i < NCH; i++) begin
				cc_reg[i] <= cc_next[i];
			end
		end
	end

endmodule

/* File: tcw_pkg.sv */
// Constants shared by the timer compare/waveform block and its tick divider.
// Assumes a 32-bit AHB-Lite register bus and word-aligned registers.
package tcw_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] TCW_OFS_CTRL   = 8'h00;
	localparam logic [7:0] TCW_OFS_CMD    = 8'h04;
	localparam logic [7:0] TCW_OFS_COUNT  = 8'h08;
	localparam logic [7:0] TCW_OFS_PER    = 8'h0c;
	localparam logic [7:0] TCW_OFS_EVCTRL = 8'h10;
	localparam logic [7:0] TCW_OFS_INVERT = 8'h14;
	localparam logic [7:0] TCW_OFS_FLAG   = 8'h18;
	localparam logic [7:0] TCW_OFS_INTEN  = 8'h1c;
	localparam logic [7:0] TCW_OFS_CMP0   = 8'h20;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int TCW_CTRL_ENABLE   = 0;
	localparam int TCW_CTRL_DOWN     = 1;
	localparam int TCW_CTRL_WAVE_LSB = 2;
	localparam int TCW_CTRL_SIZE_LSB = 4;
	localparam int TCW_CTRL_EVA_LSB  = 8;
	localparam int TCW_CTRL_PRE_LSB  = 12;
	localparam int TCW_CMD_RETRIG    = 0;
	localparam int TCW_CMD_STOP      = 1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] TCW_CTRL_RST  = 16'h0000;
	localparam logic [31:0] TCW_COUNT_RST = 32'h0000_0000;
	localparam logic [7:0]  TCW_PER_RST   = 8'hff;
	localparam logic [31:0] TCW_CC_RST    = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Event action codes
	// ----------------------------------------------------------------
	localparam logic [2:0] TCW_EVA_OFF     = 3'h0;
	localparam logic [2:0] TCW_EVA_RETRIG  = 3'h1;
	localparam logic [2:0] TCW_EVA_COUNT   = 3'h2;
	localparam logic [2:0] TCW_EVA_START   = 3'h3;

	// Counter width codes
	localparam logic [1:0] TCW_SIZE_16 = 2'h0;
	localparam logic [1:0] TCW_SIZE_8  = 2'h1;
	localparam logic [1:0] TCW_SIZE_32 = 2'h2;

	// Waveform modes in field order
	typedef enum logic [1:0] {
		TCW_NORMAL_FREQUENCY_MODE,
		TCW_MATCH_FREQUENCY_MODE,
		TCW_NORMAL_PULSE_WIDTH_MODE,
		TCW_MATCH_PULSE_WIDTH_MODE
	} tcw_wave_t;

	// Run state of the counter
	typedef enum logic {
		TCW_STOPPED,
		TCW_RUNNING
	} tcw_run_t;

endpackage

/* File: tcw_tick_div.sv */
// Prescaler that turns the system clock into the counter clock tick.
// Assumes one clock; the tick is a one-cycle enable, never a clock.
`timescale 1ns/1ps
module tcw_tick_div
	import tcw_pkg::*;
#(
	parameter int DIV_W = 10
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [3:0] prescale,
	output logic            counter_clock_tick
);

	logic [DIV_W-1:0] div_reg;
	logic [DIV_W-1:0] div_next;
	logic             tick_next;
	logic [DIV_W:0]   span;

	// ----------------------------------------------------------------
	// Divide by 2^prescale, codes above DIV_W clamp
	// ----------------------------------------------------------------
	always_comb begin
		span = (prescale > 4'(DIV_W)) ? ({1'b1, {DIV_W{1'b0}}})
			: ((DIV_W+1)'(1) << prescale);
		tick_next = 1'b0;
		div_next  = div_reg + 1'b1;
		if ({1'b0, div_reg} >= span - 1'b1) begin
			div_next  = '0;
			tick_next = 1'b1;
		end
	end

	// Registered so the tick is glitch free
	always_ff @(posedge clk) begin
		if (reset) begin
			div_reg            <= '0;
			counter_clock_tick <= 1'b0;
		end else begin
			div_reg            <= div_next;
			counter_clock_tick <= tick_next;
		end
	end

endmodule

/* File: tcw_event_src.sv */
// Event source standing in for the peripherals that feed the timer.
// Assumes one clock; each event is a one-cycle pulse, gap idle cycles apart.
`timescale 1ns/1ps
module tcw_event_src (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       go,
	input  wire logic [7:0] num,
	input  wire logic [3:0] gap,
	output logic            event_in,
	output logic            busy
);
	logic [7:0] left_reg;
	logic [3:0] wait_reg;
	// Burst engine; gap 0 gives back-to-back events, the hardest case
	always_ff @(posedge clk) begin
		if (reset || go) begin
			left_reg <= reset ? 8'h00 : num;
			wait_reg <= 4'h0;
			event_in <= 1'b0;
		end else begin
			event_in <= (left_reg != 8'h00) && (wait_reg == 4'h0);
			if (left_reg != 8'h00 && wait_reg == 4'h0) begin
				left_reg <= left_reg - 8'h01;
				wait_reg <= gap;
			end else if (wait_reg != 4'h0) begin
				wait_reg <= wait_reg - 4'h1;
			end
		end
	end
	// Busy until the last pulse has been seen
	assign busy = (left_reg != 8'h00) || event_in;
endmodule

/* File: tcw_timer_checker.sv */
// Port-level assertions for the timer compare/waveform block.
// Assumes one clock, synchronous reset, zero-wait bus slave.
`timescale 1ns/1ps
module tcw_timer_checker
	import tcw_pkg::*;
#(
	parameter int NCH = 2
) (
	input wire logic           clk,
	input wire logic           reset,
	input wire logic           hsel,
	input wire logic [31:0]    haddr,
	input wire logic [1:0]     htrans,
	input wire logic           hwrite,
	input wire logic [31:0]    hwdata,
	input wire logic           hready,
	input wire logic [31:0]    hrdata,
	input wire logic           hreadyout,
	input wire logic           hresp,
	input wire logic [NCH-1:0] match_event_out,
	input wire logic [NCH-1:0] wave_out,
	input wire logic           irq
);
	logic           ap;
	logic           wr_pend_reg;
	logic [5:0]     wr_word_reg;
	logic [7:0]     per_sh_reg;
	logic [NCH-1:0] inten_sh_reg;
	logic [NCH-1:0] evo_sh_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// Shadows of the period and the enables, landing with the data phase
	// ----------------------------------------
	assign ap = hsel && htrans[1] && hready;
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_pend_reg  <= 1'b0;
			per_sh_reg   <= TCW_PER_RST;
			inten_sh_reg <= '0;
			evo_sh_reg   <= '0;
		end else begin
			wr_pend_reg <= ap && hwrite;
			wr_word_reg <= haddr[7:2];
			if (wr_pend_reg && wr_word_reg == TCW_OFS_PER[7:2]) per_sh_reg <= hwdata[7:0];
			if (wr_pend_reg && wr_word_reg == TCW_OFS_INTEN[7:2]) inten_sh_reg <= hwdata[NCH-1:0];
			if (wr_pend_reg && wr_word_reg == TCW_OFS_EVCTRL[7:2]) evo_sh_reg <= hwdata[NCH-1:0];
		end
	end
	sequence s_rd(logic [7:0] ofs);
		ap && !hwrite && haddr[7:2] == ofs[7:2];
	endsequence
	property p_ready; hreadyout; endproperty
	property p_okay; !hresp; endproperty
	property p_rd_zero; !(ap && !hwrite) |=> hrdata == 32'h0; endproperty
	property p_per_rd; s_rd(TCW_OFS_PER) |=> hrdata == {24'h0, $past(per_sh_reg)}; endproperty
	property p_gap_rd; s_rd(8'h40) |=> hrdata == 32'h0; endproperty
	property p_irq_mask; inten_sh_reg == '0 && $past(inten_sh_reg) == '0 |-> !irq; endproperty
	property p_evo_gate; (match_event_out & ~(evo_sh_reg | $past(evo_sh_reg))) == '0; endproperty
	property p_rst_quiet; $fell(reset) |-> wave_out == '0 && !irq && match_event_out == '0; endproperty
	a_ready: assert property (p_ready) else $error("bus slave not ready");
	a_okay: assert property (p_okay) else $error("bus response not OKAY");
	a_rd_zero: assert property (p_rd_zero) else $error("read data outside a read");
	a_per_rd: assert property (p_per_rd) else $error("period readback wrong");
	a_gap_rd: assert property (p_gap_rd) else $error("unmapped read not zero");
	a_irq_mask: assert property (p_irq_mask) else $error("irq with all enables off");
	a_evo_gate: assert property (p_evo_gate) else $error("event out while disabled");
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
endmodule
bind tcw_timer tcw_timer_checker #(.NCH(NCH)) u_chk (.clk(clk), .reset(reset), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .match_event_out(match_event_out),
	.wave_out(wave_out), .irq(irq));

/* File: tcw_timer_tb_top.sv */
// Self-checking bench for the timer compare/waveform block.
// Assumes the event source model and the checker are compiled first.
`timescale 1ns/1ps
module tcw_timer_tb_top;
	import tcw_pkg::*;
	logic        clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [1:0]  htrans = 2'h0, mev, wave;
	logic [7:0]  num = 8'h0;
	logic [3:0]  gap = 4'h0;
	logic        hreadyout, hresp, event_in, busy, irq;
	int          n_errors = 0, num_checks = 0, ev0 = 0, ev1 = 0;
	// ----------------------------------------
	// Clock, parts and pulse counters
	// ----------------------------------------
	always #25 clk = ~clk;
	always @(posedge clk) if (mev[0] === 1'b1) ev0++;
	always @(posedge clk) if (mev[1] === 1'b1) ev1++;
	tcw_event_src u_src (.clk(clk), .reset(reset), .go(go), .num(num), .gap(gap),
		.event_in(event_in), .busy(busy));
	tcw_timer #(.NCH(2)) dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .event_in(event_in),
		.match_event_out(mev), .wave_out(wave), .irq(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Single word transfer; waits on ready, never on a cycle count
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	function automatic logic [31:0] ctl(input logic dn, input logic [1:0] wv,
		input logic [1:0] sz, input logic [2:0] eva);
		return {21'h0, eva, 2'h0, sz, wv, dn, 1'b1};
	endfunction
	// Burst of n events; returns once the last pulse is gone
	task automatic fire(input logic [7:0] n, input logic [3:0] g);
		@(posedge clk);
		num <= n;
		gap <= g;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do @(posedge clk); while (busy);
	endtask
	task automatic t_reset;
		rdc(TCW_OFS_CTRL, 32'h0);
		rdc(TCW_OFS_COUNT, 32'h0);
		rdc(TCW_OFS_PER, 32'hff);
		rdc(TCW_OFS_CMP0, 32'h0);
		wr(8'h40, 32'h5);
		rdc(8'h40, 32'h0);
		$display("Test reset done");
	endtask
	// Down-step from zero lands on the top value of each mode and width
	task automatic t_top;
		logic [1:0]  sz [6] = '{TCW_SIZE_8, TCW_SIZE_8, TCW_SIZE_16, TCW_SIZE_32,
			TCW_SIZE_16, TCW_SIZE_8};
		logic [1:0]  wv [6] = '{2'h0, 2'h2, 2'h0, 2'h2, 2'h1, 2'h3};
		logic [31:0] ex [6] = '{32'h5, 32'h5, 32'hffff, 32'hffffffff, 32'h7, 32'h7};
		wr(TCW_OFS_PER, 32'h5);
		wr(TCW_OFS_CMP0, 32'h7);
		for (int i = 0; i < 6; i++) begin
			wr(TCW_OFS_CTRL, 32'h0);
			wr(TCW_OFS_COUNT, 32'h0);
			wr(TCW_OFS_CTRL, ctl(1'b1, wv[i], sz[i], TCW_EVA_COUNT));
			fire(8'h1, 4'h0);
			rdc(TCW_OFS_COUNT, ex[i]);
		end
		$display("Test top done");
	endtask
	task automatic t_count;
		wr(TCW_OFS_CTRL, 32'h0);
		wr(TCW_OFS_COUNT, 32'h0);
		wr(TCW_OFS_CTRL, ctl(1'b0, 2'h0, TCW_SIZE_16, TCW_EVA_COUNT));
		fire(8'h5, 4'h0);
		rdc(TCW_OFS_COUNT, 32'h5);
		wr(TCW_OFS_CTRL, ctl(1'b1, 2'h0, TCW_SIZE_16, TCW_EVA_COUNT));
		fire(8'h2, 4'h3);
		rdc(TCW_OFS_COUNT, 32'h3);
		// Prescale code 3: one tick per 8 clocks, divider phase is free-running
		wr(TCW_OFS_CTRL, 32'h0);
		wr(TCW_OFS_COUNT, 32'h0);
		wr(TCW_OFS_CTRL, ctl(1'b0, 2'h0, TCW_SIZE_16, TCW_EVA_OFF) | 32'h0000_3000);
		repeat (64) @(posedge clk);
		bus(1'b0, TCW_OFS_COUNT, 32'h0);
		chk(32'(q >= 32'h7 && q <= 32'ha), 32'h1);
		$display("Test count done");
	endtask
	task automatic t_match;
		wr(TCW_OFS_CTRL, 32'h0);
		wr(TCW_OFS_COUNT, 32'h0);
		wr(TCW_OFS_CMP0, 32'h3);
		wr(TCW_OFS_CMP0 + 8'h4, 32'h2);
		wr(TCW_OFS_EVCTRL, 32'h1);
		wr(TCW_OFS_INTEN, 32'h0);
		wr(TCW_OFS_FLAG, 32'h3);
		ev0 = 0;
		ev1 = 0;
		wr(TCW_OFS_CTRL, ctl(1'b0, 2'h0, TCW_SIZE_16, TCW_EVA_COUNT));
		fire(8'h4, 4'h1);
		rdc(TCW_OFS_FLAG, 32'h3);
		chk(32'(ev0), 32'h1);
		chk(32'(ev1), 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(TCW_OFS_INTEN, 32'h2);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(TCW_OFS_FLAG, 32'h0);
		rdc(TCW_OFS_FLAG, 32'h3);
		wr(TCW_OFS_FLAG, 32'h2);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rdc(TCW_OFS_FLAG, 32'h1);
		$display("Test match done");
	endtask
	task automatic t_retrig;
		wr(TCW_OFS_CTRL, 32'h0);
		wr(TCW_OFS_COUNT, 32'h40);
		wr(TCW_OFS_CTRL, ctl(1'b0, 2'h0, TCW_SIZE_16, TCW_EVA_RETRIG));
		repeat (8) @(posedge clk);
		rdc(TCW_OFS_CMD, 32'h0);
		rdc(TCW_OFS_COUNT, 32'h40);
		fire(8'h1, 4'h0);
		rdc(TCW_OFS_CMD, 32'h1);
		wr(TCW_OFS_CMD, 32'h1);
		bus(1'b0, TCW_OFS_COUNT, 32'h0);
		chk(32'(q < 32'h10), 32'h1);
		wr(TCW_OFS_CTRL, ctl(1'b1, 2'h0, TCW_SIZE_16, TCW_EVA_RETRIG));
		wr(TCW_OFS_CMD, 32'h1);
		bus(1'b0, TCW_OFS_COUNT, 32'h0);
		chk(32'(q > 32'hff00 && q <= 32'hffff), 32'h1);
		wr(TCW_OFS_CMD, 32'h2);
		wr(TCW_OFS_COUNT, 32'h40);
		wr(TCW_OFS_CTRL, ctl(1'b0, 2'h0, TCW_SIZE_16, TCW_EVA_RETRIG));
		wr(TCW_OFS_CMD, 32'h1);
		bus(1'b0, TCW_OFS_COUNT, 32'h0);
		chk(32'((q - 32'h40) < 32'h10), 32'h1);
		for (int i = 0; i < 2; i++) begin
			wr(TCW_OFS_CTRL, 32'h0);
			wr(TCW_OFS_CTRL, ctl(1'b0, 2'h0, TCW_SIZE_16, TCW_EVA_START));
			rdc(TCW_OFS_CMD, 32'h0);
			if (i == 0) fire(8'h2, 4'h0);
			else wr(TCW_OFS_CMD, 32'h1);
			rdc(TCW_OFS_CMD, 32'h1);
		end
		// Start action: an event while running must not restart the count
		wr(TCW_OFS_COUNT, 32'h40);
		fire(8'h1, 4'h0);
		bus(1'b0, TCW_OFS_COUNT, 32'h0);
		chk(32'((q - 32'h40) < 32'h20), 32'h1);
		$display("Test restart_on_event_action done");
	endtask
	// Stopped in normal PWM: count 2 against compare 3 and 2 gives levels 1 and 0
	task automatic t_inv;
		wr(TCW_OFS_CTRL, 32'h8);
		wr(TCW_OFS_COUNT, 32'h2);
		wr(TCW_OFS_INVERT, 32'h0);
		repeat (2) @(posedge clk);
		chk({30'h0, wave}, 32'h1);
		wr(TCW_OFS_INVERT, 32'h3);
		repeat (2) @(posedge clk);
		chk({30'h0, wave}, 32'h2);
		$display("Test invert done");
	endtask
	task automatic end_sim;
		$display("Checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Watchdog at 20000 cycles; the whole run needs a few hundred cycles
	initial begin
		#(20000 * 50);
		n_errors++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_top();
		t_count();
		t_match();
		t_retrig();
		t_inv();
		end_sim();
	end
endmodule
